// ===== hdl/idp_pkg.sv
// constants for the instrument digital i/o ports block
`default_nettype none
package idp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address on the bus is four times the index
  localparam logic [9:0] IDX_CTRL_PORT = 10'h321; // remote inputs (rd) / spare outputs (wr)
  localparam logic [9:0] IDX_INT_PORT = 10'h322; // internal inputs (rd) / internal outputs (wr)
  localparam logic [9:0] IDX_ALM_PORT = 10'h325; // spare inputs (rd) / alarm outputs (wr)
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h330; // sticky events, write one to clear
  localparam logic [9:0] IDX_IRQ_MASK = 10'h331; // interrupt enables, same layout
  localparam logic [9:0] IDX_CONFIG = 10'h332; // block configuration

  ////////////////////////////////////////////////////////////////////////////////
  // internal input port fields
  localparam int SYNC_OK_BIT = 0; // sync health flag

  // internal output port fields
  localparam int SELF_TEST_BIT = 0; // electrical self-test
  localparam int DARK_CAL_BIT = 1; // dark calibration
  localparam int PERIPH_RST_BIT = 6; // two-wire peripherals held in reset
  localparam int CTRL_RST_N_BIT = 7; // bus controller reset, active low

  // remote control input port fields
  localparam int ZERO_REQ_BIT = 0; // zero calibration request, low = enter
  localparam int SPAN_REQ_BIT = 1; // span calibration request, low = enter
  localparam int RANGE_SEL_BIT = 2; // range select, low = high range
  localparam logic [1:0] INPUT_TOP_ONES = 2'h3; // bits 6..7 of the control and spare input ports read one

  // alarm output port fields
  localparam int HEALTHY_BIT = 4; // system healthy
  localparam int LIMIT1_BIT = 5; // limit 1 alarm or upper range
  localparam int LIMIT2_BIT = 6; // limit 2 alarm

  // interrupt event fields
  localparam int EV_SYNC_LOST = 0; // sync flag fell
  localparam int EV_ZERO_REQ = 1; // zero request asserted
  localparam int EV_SPAN_REQ = 2; // span request asserted
  localparam int EV_WIDTH = 3; // number of events

  // configuration fields
  localparam int CFG_RANGE_MODE_BIT = 0; // 1: bit 5 reports range

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] INT_OUT_RESET = 8'h80; // controller out of reset, all else off
  localparam logic [7:0] CTRL_OUT_RESET = 8'h00; // spare outputs low
  localparam logic [7:0] ALM_OUT_RESET = 8'h00; // not healthy until software says so
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0; // all interrupts masked

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // htrans[1] marks a real transfer
  localparam logic HRESP_OKAY = 1'b0; // only response ever given

endpackage : idp_pkg
`default_nettype wire

// ===== hdl/idp_ports.sv
// byte-wide digital i/o ports of the instrument, ahb-lite register slave
//
// Contract
// - internal input bit 0 reports sync health
// - writes to internal port latch eight outputs; only bits 0, 1, 6 and 7 drive outputs here
// - internal bit 0 drives electrical self-test
// - internal bit 1 enables dark calibration
// - internal bit 6 holds peripherals in reset
// - internal bit 7 is controller reset, low
// - control inputs on bits 0-5, 6-7 one
// - second input port spare, top bits one
// - control output port holds eight spare bits
// - alarm port: spares 0-3, alarms 4-7; bit 7 drives no output here
// - bit 4 high only while system healthy
// - bit 5 reports limit 1 alarm
// - alternative mode: bit 5 reports range
// - bit 6 reports limit 2 alarm
//
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none
module idp_ports (
  input wire logic clk, // 125 mhz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  input wire logic sync_ok_in, // sync health, high when good
  input wire logic remote_zero_request_n, // zero calibration request
  input wire logic remote_span_request_n, // span calibration request
  input wire logic remote_range_select, // range select contact
  input wire logic [2:0] remote_spare_in, // spare contacts, bits 3..5
  input wire logic [5:0] spare_control_in, // spare contacts of second port
  output logic electrical_self_test, // self-test enable
  output logic dark_calibration, // dark calibration enable
  output logic peripheral_reset, // two-wire peripherals reset
  output logic bus_controller_reset_n, // bus controller reset, active low
  output logic [7:0] spare_control_out, // spare outputs
  output logic system_healthy_out, // high while healthy
  output logic concentration_limit1_alarm, // limit 1 exceeded
  output logic upper_range_active, // high auto-range in use
  output logic concentration_limit2_alarm, // limit 2 exceeded
  output logic irq // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic addr_ok; // address phase hits a word inside the index window
  logic accept; // transfer taken this edge
  logic [9:0] aidx; // index of address phase
  logic wr_pend_r; // write in data phase
  logic [9:0] widx_r; // index of pending write

  assign addr_ok = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
  assign aidx = haddr[11:2];
  assign accept = hsel && htrans[1] && hready;

  // data phase tracking; hsize is not checked since only words are issued
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      widx_r <= 10'h000;
    end else begin
      wr_pend_r <= accept && hwrite && addr_ok;
      widx_r <= aidx;
    end
  end

  // zero wait states and okay answers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= idp_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= idp_pkg::HRESP_OKAY;
    end
  end

  logic wr_ctrl; // write hits control output port
  logic wr_int; // write hits internal output port
  logic wr_alm; // write hits alarm output port
  logic wr_stat; // write hits status
  logic wr_mask; // write hits mask
  logic wr_cfg; // write hits configuration

  assign wr_ctrl = wr_pend_r && (widx_r == idp_pkg::IDX_CTRL_PORT);
  assign wr_int = wr_pend_r && (widx_r == idp_pkg::IDX_INT_PORT);
  assign wr_alm = wr_pend_r && (widx_r == idp_pkg::IDX_ALM_PORT);
  assign wr_stat = wr_pend_r && (widx_r == idp_pkg::IDX_IRQ_STATUS);
  assign wr_mask = wr_pend_r && (widx_r == idp_pkg::IDX_IRQ_MASK);
  assign wr_cfg = wr_pend_r && (widx_r == idp_pkg::IDX_CONFIG);

  ////////////////////////////////////////////////////////////////////////////////
  // input capture

  logic sync_q; // sync flag, registered
  logic [5:0] ctl_q; // remote contacts, registered
  logic [5:0] spare_q; // second port contacts, registered
  logic sync_d; // previous sync flag
  logic zero_d; // previous zero request level
  logic span_d; // previous span request level

  // register the contacts once so reads and edge detection see one value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 1'b1;
      ctl_q <= 6'h3F;
      spare_q <= 6'h3F;
    end else begin
      sync_q <= sync_ok_in;
      ctl_q <= {remote_spare_in, remote_range_select,
                remote_span_request_n, remote_zero_request_n};
      spare_q <= spare_control_in;
    end
  end

  // previous levels for event edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_d <= 1'b1;
      zero_d <= 1'b1;
      span_d <= 1'b1;
    end else begin
      sync_d <= sync_q;
      zero_d <= ctl_q[idp_pkg::ZERO_REQ_BIT];
      span_d <= ctl_q[idp_pkg::SPAN_REQ_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output latches

  logic [7:0] int_out_r; // internal output latch
  logic [7:0] ctrl_out_r; // spare control output latch
  logic [7:0] alm_out_r; // alarm output latch, spares stored only
  logic [7:0] alm_nxt; // next alarm latch
  logic mode_r; // bit 5 reports range when set
  logic mode_nxt; // next mode

  // internal output port; read traffic never reaches it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_out_r <= idp_pkg::INT_OUT_RESET;
    end else if (wr_int) begin
      int_out_r <= hwdata[7:0];
    end
  end

  assign electrical_self_test = int_out_r[idp_pkg::SELF_TEST_BIT];
  assign dark_calibration = int_out_r[idp_pkg::DARK_CAL_BIT];
  assign peripheral_reset = int_out_r[idp_pkg::PERIPH_RST_BIT];
  assign bus_controller_reset_n = int_out_r[idp_pkg::CTRL_RST_N_BIT];

  // spare control outputs, no function assigned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_out_r <= idp_pkg::CTRL_OUT_RESET;
    end else if (wr_ctrl) begin
      ctrl_out_r <= hwdata[7:0];
    end
  end

  assign spare_control_out = ctrl_out_r;

  // next values so the bit 5 steering flops follow in the same edge
  always_comb begin
    alm_nxt = wr_alm ? hwdata[7:0] : alm_out_r;
    mode_nxt = wr_cfg ? hwdata[idp_pkg::CFG_RANGE_MODE_BIT] : mode_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alm_out_r <= idp_pkg::ALM_OUT_RESET;
      mode_r <= 1'b0;
    end else begin
      alm_out_r <= alm_nxt;
      mode_r <= mode_nxt;
    end
  end

  // bit 5 goes to one of two outputs; the other is held low so a stale
  // alarm never shows after the mode changes
  logic limit1_r; // limit 1 alarm flop
  logic range_r; // upper range flop

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limit1_r <= 1'b0;
      range_r <= 1'b0;
    end else begin
      limit1_r <= alm_nxt[idp_pkg::LIMIT1_BIT] & ~mode_nxt;
      range_r <= alm_nxt[idp_pkg::LIMIT1_BIT] & mode_nxt;
    end
  end

  assign system_healthy_out = alm_out_r[idp_pkg::HEALTHY_BIT];
  assign concentration_limit1_alarm = limit1_r;
  assign upper_range_active = range_r;
  assign concentration_limit2_alarm = alm_out_r[idp_pkg::LIMIT2_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts

  logic [idp_pkg::EV_WIDTH-1:0] ev; // one-cycle events
  logic [idp_pkg::EV_WIDTH-1:0] stat_r; // sticky status
  logic [idp_pkg::EV_WIDTH-1:0] mask_r; // interrupt enables
  logic irq_r; // interrupt flop

  assign ev[idp_pkg::EV_SYNC_LOST] = sync_d & ~sync_q;
  assign ev[idp_pkg::EV_ZERO_REQ] = zero_d & ~ctl_q[idp_pkg::ZERO_REQ_BIT];
  assign ev[idp_pkg::EV_SPAN_REQ] = span_d & ~ctl_q[idp_pkg::SPAN_REQ_BIT];

  // one generate per event bit; a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < idp_pkg::EV_WIDTH; gi++) begin : g_stat
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stat_r[gi] <= 1'b0;
        end else if (ev[gi]) begin
          stat_r[gi] <= 1'b1;
        end else if (wr_stat && hwdata[gi]) begin
          stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= idp_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      mask_r <= hwdata[idp_pkg::EV_WIDTH-1:0];
    end
  end

  // one cycle behind the status bits, kept a flop for a clean output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read data

  logic [31:0] rd_val; // value for the address being read

  // reads see input ports only at shared addresses; unmapped reads zero
  always_comb begin
    rd_val = 32'h00000000;
    if (addr_ok) begin
      unique case (aidx)
        idp_pkg::IDX_CTRL_PORT: rd_val[7:0] = {idp_pkg::INPUT_TOP_ONES, ctl_q};
        idp_pkg::IDX_INT_PORT: rd_val[idp_pkg::SYNC_OK_BIT] = sync_q;
        idp_pkg::IDX_ALM_PORT: rd_val[7:0] = {idp_pkg::INPUT_TOP_ONES, spare_q};
        idp_pkg::IDX_IRQ_STATUS: rd_val[idp_pkg::EV_WIDTH-1:0] = stat_r;
        idp_pkg::IDX_IRQ_MASK: rd_val[idp_pkg::EV_WIDTH-1:0] = mask_r;
        idp_pkg::IDX_CONFIG: rd_val[idp_pkg::CFG_RANGE_MODE_BIT] = mode_r;
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  // sampled at the address phase; the data phase then shows it from a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (accept && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence wr_int_s;
    wr_pend_r && (widx_r == idp_pkg::IDX_INT_PORT);
  endsequence

  sequence wr_alm_s;
    wr_pend_r && (widx_r == idp_pkg::IDX_ALM_PORT);
  endsequence

  sequence rd_at_s(logic [9:0] idx);
    accept && !hwrite && addr_ok && (aidx == idx);
  endsequence

  internal_latch_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_int_s |=> int_out_r == $past(hwdata[7:0]))
    else $error("internal output latch missed a write");

  self_test_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_int_s |=> electrical_self_test == $past(hwdata[0]))
    else $error("self-test output wrong after write");

  dark_cal_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_int_s |=> dark_calibration == $past(hwdata[1]))
    else $error("dark calibration output wrong after write");

  periph_reset_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_int_s |=> peripheral_reset == $past(hwdata[6]))
    else $error("peripheral reset wrong after write");

  ctrl_reset_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !wr_pend_r |=> $stable(bus_controller_reset_n))
    else $error("controller reset moved without a write");

  sync_read_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_at_s(idp_pkg::IDX_INT_PORT) |=> hrdata == {31'h00000000, $past(sync_q)})
    else $error("sync flag read back wrong");

  ctrl_in_read_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_at_s(idp_pkg::IDX_CTRL_PORT) |=> hrdata[7:6] == 2'h3 && hrdata[5:0] == $past(ctl_q))
    else $error("control input port read wrong");

  spare_in_read_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_at_s(idp_pkg::IDX_ALM_PORT) |=> hrdata[7:6] == 2'h3 && hrdata[5:0] == $past(spare_q))
    else $error("second input port top bits not one");

  spare_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_pend_r && (widx_r == idp_pkg::IDX_CTRL_PORT) |=> spare_control_out == $past(hwdata[7:0]))
    else $error("spare outputs missed a write");

  healthy_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_alm_s |=> system_healthy_out == $past(hwdata[4]))
    else $error("healthy output wrong after write");

  limit1_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_alm_s ##0 !mode_r ##0 !wr_cfg |=>
      concentration_limit1_alarm == $past(hwdata[5]) && !upper_range_active)
    else $error("limit 1 alarm wrong after write");

  range_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_alm_s ##0 mode_r ##0 !wr_cfg |=>
      upper_range_active == $past(hwdata[5]) && !concentration_limit1_alarm)
    else $error("upper range output wrong after write");

  limit2_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_alm_s |=> concentration_limit2_alarm == $past(hwdata[6]))
    else $error("limit 2 alarm wrong after write");

  read_no_write_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_at_s(idp_pkg::IDX_INT_PORT) ##0 !wr_pend_r |=> $stable(int_out_r))
    else $error("read changed the internal output latch");

  zero_event_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(ctl_q[0]) ##1 !wr_stat |-> stat_r[1] [*2])
    else $error("zero request did not set its status");

  irq_level_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (|(stat_r & mask_r)) |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule : idp_ports
`default_nettype wire

// ===== sim/idp_contact_model.sv
// model of the remote contact closures wired to the control input port
`default_nettype none
module idp_contact_model (
  input wire logic clk, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic zero_cmd, // bench asks for zero calibration
  input wire logic span_cmd, // bench asks for span calibration
  input wire logic hi_range_cmd, // bench asks for the high range
  output logic zero_n, // zero contact, low = enter
  output logic span_n, // span contact, low = enter
  output logic range_sel // range contact, low = high range
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // contacts change just after an edge, like a real relay sampled by the block;
  // open contacts idle high so nothing is requested while in reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_n <= 1'b1; // no zero request
      span_n <= 1'b1; // no span request
      range_sel <= 1'b1; // low range
    end else begin
      zero_n <= ~zero_cmd;
      span_n <= ~span_cmd;
      range_sel <= ~hi_range_cmd;
    end
  end
endmodule : idp_contact_model
`default_nettype wire

// ===== sim/idp_ports_tb.sv
// self-checking testbench for the instrument digital i/o ports block
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module idp_ports_tb;
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic clk = 1'b0; // 125 mhz clock
  logic reset_n = 1'b0; // asynchronous reset, active low
  logic hsel = 1'b0; // slave select
  logic [31:0] haddr = 32'h0; // byte address
  logic [1:0] htrans = 2'h0; // idle at start
  logic hwrite = 1'b0; // write flag
  logic [31:0] hwdata = 32'h0; // write data
  logic hreadyout; // slave ready, fed back as hready
  logic hresp; // response
  logic [31:0] hrdata; // read data
  logic sync_ok_in = 1'b1; // sync healthy
  logic zero_cmd = 1'b0; // contact model requests
  logic span_cmd = 1'b0;
  logic hi_cmd = 1'b0;
  logic zero_n, span_n, range_sel; // contacts from the model
  logic [2:0] rem_spare = 3'h0; // spare contacts of port 0x321
  logic [5:0] spare_in = 6'h0; // spare contacts of port 0x325
  logic self_test, dark_cal, periph_rst, ctrl_rst_n, irq; // internal outputs and interrupt
  logic healthy, limit1, upper, limit2; // alarm outputs
  logic [7:0] spare_out; // spare control outputs
  int mismatches = 0; // failed comparisons
  int n_tests = 0; // comparisons made
  logic [7:0] pats [5] = '{8'h01, 8'h02, 8'h3C, 8'h40, 8'hC3}; // single-bit and mixed bit patterns

  always #4 clk = ~clk; // 8 ns period

  ////////////////////////////////////////////////////////////////////////////////
  // design and far-side model
  idp_ports idp_ports_inst (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sync_ok_in(sync_ok_in),
    .remote_zero_request_n(zero_n), .remote_span_request_n(span_n),
    .remote_range_select(range_sel), .remote_spare_in(rem_spare),
    .spare_control_in(spare_in), .electrical_self_test(self_test),
    .dark_calibration(dark_cal), .peripheral_reset(periph_rst),
    .bus_controller_reset_n(ctrl_rst_n), .spare_control_out(spare_out),
    .system_healthy_out(healthy), .concentration_limit1_alarm(limit1),
    .upper_range_active(upper), .concentration_limit2_alarm(limit2), .irq(irq));
  idp_contact_model idp_contact_model_inst (.clk(clk), .reset_n(reset_n),
    .zero_cmd(zero_cmd), .span_cmd(span_cmd), .hi_range_cmd(hi_cmd), .zero_n(zero_n),
    .span_n(span_n), .range_sel(range_sel));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, the only place the run ends
  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // bounded wait for hready; a hang counts as a mismatch
  task automatic wait_ready;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) return;
    end
    `CHK("hreadyout", 1'b1, hreadyout)
    end_of_test();
  endtask : wait_ready

  // one single ahb-lite transfer; returns at the falling edge of the next cycle
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, idx, 2'h0};
    htrans <= idp_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0; // address phase over, data phase follows
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata; // taken at the edge that ends the data phase
    `CHK("hresp", idp_pkg::HRESP_OKAY, hresp)
    @(negedge clk);
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus(1'b1, idx, {24'h0, d}, unused);
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e, input string nm);
    logic [31:0] got;
    bus(1'b0, idx, 32'h0, got);
    `CHK(nm, e, got)
  endtask : rd_chk

  // internal control lines against the latched byte
  task automatic chk_int(input logic [7:0] d);
    `CHK("self test", d[0], self_test)
    `CHK("dark cal", d[1], dark_cal)
    `CHK("periph reset", d[6], periph_rst)
    `CHK("ctrl reset_n", d[7], ctrl_rst_n)
  endtask : chk_int

  // alarm lines; mode 1 routes bit 5 to the range line instead
  task automatic chk_alm(input logic [7:0] d, input logic m);
    `CHK("healthy", d[4], healthy)
    `CHK("limit1", m ? 1'b0 : d[5], limit1)
    `CHK("upper range", m ? d[5] : 1'b0, upper)
    `CHK("limit2", d[6], limit2)
  endtask : chk_alm

  // drive contacts and sync, let them pass the input flops, read all three ports
  task automatic chk_in(input logic sy, z, s, h, input logic [2:0] rs, input logic [5:0] sc);
    @(posedge clk);
    sync_ok_in <= sy;
    zero_cmd <= z;
    span_cmd <= s;
    hi_cmd <= h;
    rem_spare <= rs;
    spare_in <= sc;
    repeat (4) @(negedge clk); // model edge plus input flop, with margin
    rd_chk(idp_pkg::IDX_INT_PORT, {31'h0, sy}, "int in");
    rd_chk(idp_pkg::IDX_CTRL_PORT, {24'h0, 2'h3, rs, ~h, ~s, ~z}, "ctrl in");
    rd_chk(idp_pkg::IDX_ALM_PORT, {24'h0, 2'h3, sc}, "spare in");
  endtask : chk_in

  // bounded poll of the interrupt level
  task automatic wait_irq(input logic e);
    for (int i = 0; i < 16; i++) begin
      if (irq === e) break;
      @(negedge clk);
    end
    `CHK("irq", e, irq)
    // a line that never settles is a hang: stop here rather than run on
    if (irq !== e) end_of_test();
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    // reset state: controller out of reset, all else off
    chk_int(8'h80);
    `CHK("spare out", 8'h00, spare_out)
    chk_alm(8'h00, 1'b0);
    `CHK("irq", 1'b0, irq)
    foreach (pats[i]) begin
      wr(idp_pkg::IDX_INT_PORT, pats[i]);
      chk_int(pats[i]);
    end
    wr(idp_pkg::IDX_CTRL_PORT, 8'hA5);
    `CHK("spare out", 8'hA5, spare_out)
    wr(idp_pkg::IDX_CTRL_PORT, 8'h5A);
    `CHK("spare out", 8'h5A, spare_out)
    // both routings of bit 5, every alarm bit toggled
    for (int m = 0; m < 2; m++) begin
      wr(idp_pkg::IDX_CONFIG, {7'h0, m[0]});
      foreach (pats[i]) begin
        wr(idp_pkg::IDX_ALM_PORT, pats[i] ^ 8'h70);
        chk_alm(pats[i] ^ 8'h70, m[0]);
      end
    end
    // reads at shared addresses give inputs, not the latches
    chk_in(1'b0, 1'b1, 1'b0, 1'b1, 3'h5, 6'h2A);
    chk_in(1'b1, 1'b0, 1'b1, 1'b0, 3'h2, 6'h15);
    // unmapped place: reads zero, write leaves every latch alone
    rd_chk(10'h300, 32'h0, "unmapped");
    wr(10'h323, 8'hFF);
    `CHK("spare out", 8'h5A, spare_out)
    chk_int(pats[4]);
    chk_alm(pats[4] ^ 8'h70, 1'b1);
    // all three events latched while masked
    rd_chk(idp_pkg::IDX_IRQ_STATUS, 32'h7, "status");
    `CHK("irq", 1'b0, irq)
    wr(idp_pkg::IDX_IRQ_MASK, 8'h02);
    wait_irq(1'b1);
    rd_chk(idp_pkg::IDX_IRQ_MASK, 32'h2, "mask");
    wr(idp_pkg::IDX_IRQ_STATUS, 8'h02); // clear the unmasked one only
    wait_irq(1'b0);
    rd_chk(idp_pkg::IDX_IRQ_STATUS, 32'h5, "status");
    wr(idp_pkg::IDX_IRQ_STATUS, 8'h05);
    rd_chk(idp_pkg::IDX_IRQ_STATUS, 32'h0, "status");
    // a fresh zero request raises the line again
    chk_in(1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 6'h00);
    wait_irq(1'b1);
    wr(idp_pkg::IDX_IRQ_STATUS, 8'h07);
    wait_irq(1'b0);
    end_of_test();
  end
endmodule : idp_ports_tb
`default_nettype wire
